//--- include/dtu_pkg.sv
package dtu_pkg;

   // ==========================================================
   // widths and timing counts
   // ==========================================================
   localparam int DIV_W = 17;        // divisor 1..65536 needs 17 bits
   localparam int OVERSAMPLE = 16;   // sampling ticks per bit period
   localparam int START_LOW = 8;     // low for more than 7 samples
   localparam int FIRST_SAMPLE = 24; // falling edge to first data bit
   localparam int BIT_SAMPLES = 16;  // one bit period in samples
   localparam int FIRST_WAIT = FIRST_SAMPLE - START_LOW;
   localparam int DATA_BITS = 8;
   localparam int FRAME_TAIL_PAR = 10;   // data, parity, stop
   localparam int FRAME_TAIL_NOPAR = 9;  // data, stop

   // ==========================================================
   // reset values and line levels
   // ==========================================================
   localparam logic [DIV_W-1:0] DIVISOR_RESET = 17'h00000;
   localparam logic [DIV_W-1:0] DIVISOR_ONE = 17'h00001;
   localparam logic [7:0] HOLD_RESET = 8'h00;
   localparam logic IDLE_LEVEL = 1'b1;
   localparam logic START_LEVEL = 1'b0;

   // ==========================================================
   // check bit selection
   // ==========================================================
   localparam logic [2:0] PAR_EVEN = 3'h0;
   localparam logic [2:0] PAR_ODD = 3'h1;
   localparam logic [2:0] PAR_SPACE = 3'h2;
   localparam logic [2:0] PAR_MARK = 3'h3;
   localparam logic [2:0] PAR_NONE = 3'h4; // 4 and above: no check bit

   // ==========================================================
   // carriers
   // ==========================================================
   typedef struct packed {
      logic receiver_turn_on;
      logic receiver_turn_off;
      logic receiver_abort;
      logic transmitter_turn_on;
      logic transmitter_turn_off;
      logic transmitter_abort;
      logic clear_error_flags;
   } dtu_cmd_s;

   typedef struct packed {
      logic receive_ready;
      logic overrun_flag;
      logic check_bit_mismatch_flag;
      logic framing_error_flag;
      logic transmit_ready;
      logic transmit_drained;
   } dtu_flags_s;

   typedef enum logic [1:0] {
      RX_OFF = 2'h0,
      RX_HUNT = 2'h1,
      RX_RECV = 2'h3
   } dtu_rx_state_e;

   typedef enum logic [1:0] {
      TX_OFF = 2'h0,
      TX_IDLE = 2'h1,
      TX_SHIFT = 2'h3
   } dtu_tx_state_e;

endpackage

//--- design/dtu_rate_gen.sv
`timescale 1ns/1ps
module dtu_rate_gen (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [dtu_pkg::DIV_W-1:0] rate_divisor,
   output logic sample_tick,
   output logic rate_active
);
   import dtu_pkg::*;

   logic [DIV_W-1:0] div_cnt_reg;

   // ==========================================================
   // sampling tick at master clock over divisor
   // ==========================================================
   // a shrinking divisor wraps at once rather than running on
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_reg <= DIVISOR_ONE;
         sample_tick <= 1'b0;
         rate_active <= 1'b0;
      end else if (rate_divisor == DIVISOR_RESET) begin
         div_cnt_reg <= DIVISOR_ONE;
         sample_tick <= 1'b0;
         rate_active <= 1'b0;
      end else begin
         rate_active <= 1'b1;
         if (div_cnt_reg >= rate_divisor) begin
            div_cnt_reg <= DIVISOR_ONE;
            sample_tick <= 1'b1;
         end else begin
            div_cnt_reg <= div_cnt_reg + DIVISOR_ONE;
            sample_tick <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_stop_at_zero;
      rate_divisor == DIVISOR_RESET |=> !sample_tick && !rate_active;
   endproperty
   a_stop_at_zero: assert property (p_stop_at_zero)
      else $error("tick while divisor is zero");

   property p_div_one;
      rate_divisor == DIVISOR_ONE [*2] |=> sample_tick;
   endproperty
   a_div_one: assert property (p_div_one)
      else $error("divisor one must tick every cycle");
endmodule

//--- design/dtu_uart.sv
`timescale 1ns/1ps
module dtu_uart (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   input wire logic [dtu_pkg::DIV_W-1:0] rate_divisor,
   input wire logic [2:0] check_bit_kind,
   input wire dtu_pkg::dtu_cmd_s cmd,
   input wire logic tx_write,
   input wire logic [7:0] tx_data,
   input wire logic rx_read,
   output logic [7:0] rx_data,
   output dtu_pkg::dtu_flags_s flags
);
   import dtu_pkg::*;

   // ==========================================================
   // declarations
   // ==========================================================
   logic sample_tick;
   logic rate_active;
   logic rx_meta_reg;
   logic rx_sync_reg;
   dtu_rx_state_e rx_state_reg;
   logic rx_stop_pend_reg;
   logic [4:0] rx_cnt_reg;
   logic [3:0] rx_idx_reg;
   logic [7:0] rx_shift_reg;
   logic rx_par_reg;
   logic rx_ready_reg;
   logic ovr_reg;
   logic par_err_reg;
   logic frm_err_reg;
   logic rx_sample_c;
   logic rx_done_c;
   logic [4:0] rx_wait_c;
   logic par_on_c;
   dtu_tx_state_e tx_state_reg;
   logic tx_stop_pend_reg;
   logic thr_full_reg;
   logic [7:0] thr_data_reg;
   logic [9:0] tx_shift_reg;
   logic [3:0] tx_left_reg;
   logic [3:0] tx_phase_reg;
   logic tx_out_reg;
   logic tx_ready_reg;
   logic tx_drained_reg;
   logic tx_accept_c;
   logic tx_phase_end_c;
   logic tx_frame_end_c;
   logic tx_load_c;

   // expected check bit for a data byte
   function automatic logic check_bit(input logic [2:0] kind,
                                      input logic [7:0] data);
      case (kind)
         PAR_EVEN: check_bit = ^data;
         PAR_ODD: check_bit = ~^data;
         PAR_SPACE: check_bit = 1'b0;
         PAR_MARK: check_bit = 1'b1;
         default: check_bit = 1'b1;
      endcase
   endfunction

   // ==========================================================
   // shared rate generator
   // ==========================================================
   dtu_rate_gen u_rate (
      .mclk(mclk),
      .rst_n(rst_n),
      .rate_divisor(rate_divisor),
      .sample_tick(sample_tick),
      .rate_active(rate_active)
   );

   assign par_on_c = check_bit_kind < PAR_NONE;

   // ==========================================================
   // receive synchroniser
   // ==========================================================
   // line idles high, so reset to the idle level avoids a false start
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_meta_reg <= IDLE_LEVEL;
         rx_sync_reg <= IDLE_LEVEL;
      end else begin
         rx_meta_reg <= serial_in_pin;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   // ==========================================================
   // receiver sequencing
   // ==========================================================
   // first wait completes 24 samples from the edge; later waits 16
   always_comb begin
      rx_wait_c = (rx_idx_reg == 4'h0) ? 5'(FIRST_WAIT)
                                       : 5'(BIT_SAMPLES);
      rx_sample_c = (rx_state_reg == RX_RECV) && sample_tick &&
                    (rx_cnt_reg == rx_wait_c - 5'h01);
      rx_done_c = rx_sample_c &&
                  (rx_idx_reg == (par_on_c ? 4'(DATA_BITS + 1)
                                           : 4'(DATA_BITS)));
   end

   // receiver state; abort beats every other command
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_reg <= RX_OFF;
         rx_stop_pend_reg <= 1'b0;
      end else if (cmd.receiver_abort) begin
         rx_state_reg <= RX_OFF;
         rx_stop_pend_reg <= 1'b0;
      end else begin
         case (rx_state_reg)
            RX_OFF: begin
               if (cmd.receiver_turn_on && !cmd.receiver_turn_off)
                  rx_state_reg <= RX_HUNT;
            end
            RX_HUNT: begin
               if (cmd.receiver_turn_off)
                  rx_state_reg <= RX_OFF;
               else if (sample_tick && !rx_sync_reg &&
                        rx_cnt_reg == 5'(START_LOW - 1))
                  rx_state_reg <= RX_RECV;
            end
            RX_RECV: begin
               if (cmd.receiver_turn_off)
                  rx_stop_pend_reg <= 1'b1;
               else if (cmd.receiver_turn_on)
                  rx_stop_pend_reg <= 1'b0;
               if (rx_done_c) begin
                  rx_stop_pend_reg <= 1'b0;
                  // no idle timeout: straight back to hunting, or to off if a turn-off is pending
                  rx_state_reg <= (rx_stop_pend_reg ||
                                   cmd.receiver_turn_off)
                                  ? RX_OFF : RX_HUNT;
               end
            end
            default: rx_state_reg <= RX_OFF;
         endcase
      end
   end

   // sample counter: consecutive low samples, then bit timing
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_cnt_reg <= 5'h00;
         rx_idx_reg <= 4'h0;
      end else if (cmd.receiver_abort || rx_state_reg == RX_OFF) begin
         rx_cnt_reg <= 5'h00;
         rx_idx_reg <= 4'h0;
      end else if (sample_tick) begin
         if (rx_state_reg == RX_HUNT) begin
            rx_idx_reg <= 4'h0;
            if (rx_sync_reg)
               rx_cnt_reg <= 5'h00;
            else if (rx_cnt_reg == 5'(START_LOW - 1))
               rx_cnt_reg <= 5'h00;
            else
               rx_cnt_reg <= rx_cnt_reg + 5'h01;
         end else if (rx_sample_c) begin
            rx_cnt_reg <= 5'h00;
            rx_idx_reg <= rx_idx_reg + 4'h1;
         end else begin
            rx_cnt_reg <= rx_cnt_reg + 5'h01;
         end
      end
   end

   // data bits arrive least significant first, fixed eight bits
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_shift_reg <= HOLD_RESET;
         rx_par_reg <= 1'b0;
      end else if (rx_sample_c) begin
         if (rx_idx_reg < 4'(DATA_BITS))
            rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
         else if (rx_idx_reg == 4'(DATA_BITS) && par_on_c)
            rx_par_reg <= rx_sync_reg;
      end
   end

   // ==========================================================
   // receive holding and flags
   // ==========================================================
   // completion wins over a read in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_data <= HOLD_RESET;
         rx_ready_reg <= 1'b0;
      end else if (rx_done_c) begin
         rx_data <= rx_shift_reg;
         rx_ready_reg <= 1'b1;
      end else if (rx_read) begin
         rx_ready_reg <= 1'b0;
      end
   end

   // sticky errors; a new error beats the clear command
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ovr_reg <= 1'b0;
         par_err_reg <= 1'b0;
         frm_err_reg <= 1'b0;
      end else begin
         if (rx_done_c && rx_ready_reg && !rx_read)
            ovr_reg <= 1'b1;
         else if (cmd.clear_error_flags)
            ovr_reg <= 1'b0;
         if (rx_done_c && par_on_c &&
             rx_par_reg != check_bit(check_bit_kind, rx_shift_reg))
            par_err_reg <= 1'b1;
         else if (cmd.clear_error_flags)
            par_err_reg <= 1'b0;
         if (rx_done_c && !rx_sync_reg)
            frm_err_reg <= 1'b1;
         else if (cmd.clear_error_flags)
            frm_err_reg <= 1'b0;
      end
   end

   // ==========================================================
   // transmitter timing terms
   // ==========================================================
   always_comb begin
      tx_accept_c = tx_write && tx_state_reg != TX_OFF &&
                    !cmd.transmitter_abort;
      tx_phase_end_c = tx_state_reg == TX_SHIFT && sample_tick &&
                       tx_phase_reg == 4'(OVERSAMPLE - 1);
      tx_frame_end_c = tx_phase_end_c && tx_left_reg == 4'h0;
      // back to back frames: no guard time between them
      tx_load_c = thr_full_reg && rate_active &&
                  (tx_state_reg == TX_IDLE || tx_frame_end_c);
   end

   // transmitter state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_reg <= TX_OFF;
         tx_stop_pend_reg <= 1'b0;
      end else if (cmd.transmitter_abort) begin
         tx_state_reg <= TX_OFF;
         tx_stop_pend_reg <= 1'b0;
      end else begin
         if (cmd.transmitter_turn_off)
            tx_stop_pend_reg <= 1'b1;
         else if (cmd.transmitter_turn_on)
            tx_stop_pend_reg <= 1'b0;
         case (tx_state_reg)
            TX_OFF: begin
               if (cmd.transmitter_turn_on && !cmd.transmitter_turn_off)
                  tx_state_reg <= TX_IDLE;
            end
            TX_IDLE: begin
               if (tx_load_c)
                  tx_state_reg <= TX_SHIFT;
               else if ((cmd.transmitter_turn_off || tx_stop_pend_reg)
                        && !tx_accept_c) begin
                  tx_state_reg <= TX_OFF;
                  tx_stop_pend_reg <= 1'b0;
               end
            end
            TX_SHIFT: begin
               if (tx_frame_end_c && !tx_load_c)
                  tx_state_reg <= TX_IDLE;
            end
            default: tx_state_reg <= TX_OFF;
         endcase
      end
   end

   // holding register; a write in the transfer cycle stays held
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         thr_full_reg <= 1'b0;
         thr_data_reg <= HOLD_RESET;
      end else if (cmd.transmitter_abort) begin
         thr_full_reg <= 1'b0;
      end else if (tx_accept_c) begin
         thr_full_reg <= 1'b1;
         thr_data_reg <= tx_data;
      end else if (tx_load_c) begin
         thr_full_reg <= 1'b0;
      end
   end

   // shifter and line driver; start bit goes out on load
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_shift_reg <= 10'h3FF;
         tx_left_reg <= 4'h0;
         tx_phase_reg <= 4'h0;
         tx_out_reg <= IDLE_LEVEL;
      end else if (cmd.transmitter_abort) begin
         tx_out_reg <= IDLE_LEVEL;
         tx_left_reg <= 4'h0;
         tx_phase_reg <= 4'h0;
      end else if (tx_load_c) begin
         tx_out_reg <= START_LEVEL;
         tx_phase_reg <= 4'h0;
         if (par_on_c) begin
            tx_shift_reg <= {1'b1,
                             check_bit(check_bit_kind, thr_data_reg),
                             thr_data_reg};
            tx_left_reg <= 4'(FRAME_TAIL_PAR);
         end else begin
            tx_shift_reg <= {2'b11, thr_data_reg};
            tx_left_reg <= 4'(FRAME_TAIL_NOPAR);
         end
      end else if (tx_frame_end_c || tx_state_reg != TX_SHIFT) begin
         tx_out_reg <= IDLE_LEVEL;
      end else if (sample_tick) begin
         tx_phase_reg <= tx_phase_reg + 4'h1;
         if (tx_phase_end_c) begin
            tx_out_reg <= tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
         end
      end
   end

   // ==========================================================
   // transmit status
   // ==========================================================
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ready_reg <= 1'b0;
         tx_drained_reg <= 1'b0;
      end else if (cmd.transmitter_abort) begin
         tx_ready_reg <= 1'b0;
         tx_drained_reg <= 1'b0;
      end else if (tx_state_reg == TX_OFF) begin
         tx_ready_reg <= cmd.transmitter_turn_on &&
                         !cmd.transmitter_turn_off;
         tx_drained_reg <= cmd.transmitter_turn_on &&
                           !cmd.transmitter_turn_off;
      end else begin
         if (tx_accept_c)
            tx_ready_reg <= 1'b0;
         else if (tx_load_c)
            tx_ready_reg <= 1'b1;
         if (tx_accept_c || tx_load_c)
            tx_drained_reg <= 1'b0;
         else if (tx_frame_end_c && !thr_full_reg)
            tx_drained_reg <= 1'b1;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign serial_out_pin = tx_out_reg;
   assign flags = '{receive_ready: rx_ready_reg,
                    overrun_flag: ovr_reg,
                    check_bit_mismatch_flag: par_err_reg,
                    framing_error_flag: frm_err_reg,
                    transmit_ready: tx_ready_reg,
                    transmit_drained: tx_drained_reg};

   // ==========================================================
   // assertions
   // ==========================================================
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_rx_abort;
      cmd.receiver_abort |=> rx_state_reg == RX_OFF && rx_cnt_reg == 5'h00;
   endproperty
   a_rx_abort: assert property (p_rx_abort)
      else $error("receiver still active after abort");

   property p_start_len;
      rx_state_reg == RX_RECV && $past(rx_state_reg) == RX_HUNT |->
         $past(rx_cnt_reg) == 5'(START_LOW - 1) && !$past(rx_sync_reg);
   endproperty
   a_start_len: assert property (p_start_len)
      else $error("start accepted without eight low samples");

   property p_rx_ready;
      rx_read && !rx_done_c |=> !flags.receive_ready;
   endproperty
   a_rx_ready: assert property (p_rx_ready)
      else $error("receive ready not cleared by read");

   property p_overrun;
      $rose(ovr_reg) |-> $past(rx_ready_reg) && $past(rx_done_c);
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun without unread character");

   property p_err_clear;
      cmd.clear_error_flags && !rx_done_c |=>
         !ovr_reg && !par_err_reg && !frm_err_reg;
   endproperty
   a_err_clear: assert property (p_err_clear)
      else $error("error flags survived clear command");

   property p_frame_err;
      $rose(frm_err_reg) |-> $rose(rx_ready_reg) || $past(rx_done_c);
   endproperty
   a_frame_err: assert property (p_frame_err)
      else $error("framing error not raised with completion");

   property p_tx_abort;
      cmd.transmitter_abort |=> tx_state_reg == TX_OFF && serial_out_pin &&
                                !thr_full_reg;
   endproperty
   a_tx_abort: assert property (p_tx_abort)
      else $error("transmitter not stopped by abort");

   property p_idle_high;
      tx_state_reg != TX_SHIFT && !$past(tx_load_c) |-> serial_out_pin;
   endproperty
   a_idle_high: assert property (p_idle_high)
      else $error("output low without a frame");

   property p_drained;
      flags.transmit_drained |-> !thr_full_reg && tx_state_reg != TX_SHIFT;
   endproperty
   a_drained: assert property (p_drained)
      else $error("drained flag with work pending");

   property p_start_bit;
      tx_load_c && !cmd.transmitter_abort |=> !serial_out_pin;
   endproperty
   a_start_bit: assert property (p_start_bit)
      else $error("no start bit after load");
endmodule

//--- dv/dtu_term.sv
`timescale 1ns/1ps
// ======================================================
// serial terminal facing the pins
// ======================================================
module dtu_term (
   input wire logic mclk,
   input wire logic [16:0] div,
   input wire logic [2:0] kind,
   input wire logic tx_line,
   output logic rx_line
);
   logic [7:0] got;
   logic gpar;
   logic gstop;
   int frames = 0;
   initial rx_line = 1'b1;
   // sampling ticks (16 per bit) counted in master clock cycles
   task automatic ticks(input int n);
      repeat (n * div) @(posedge mclk);
   endtask
   // one frame; caller picks check bit and stop level to inject faults
   task automatic send(input logic [7:0] d, input logic p, input logic s);
      logic [10:0] f;
      f = {s, p, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         if (i != 9 || kind < 3'h4) begin
            rx_line <= f[i];
            // a low stop is cut short: its tail must not pass as a start
            ticks((i == 10 && !s) ? 12 : 16);
         end
      end
      rx_line <= 1'b1; // idle high between frames
      ticks(16);
      #1; // hand back off the edge so callers never race the design
   endtask
   // mid-bit sampling of every frame the block sends
   always begin
      @(negedge tx_line);
      ticks(8);
      for (int i = 0; i < 8; i++) begin
         ticks(16);
         got[i] = tx_line;
      end
      if (kind < 3'h4) begin
         ticks(16);
         gpar = tx_line;
      end
      ticks(16);
      gstop = tx_line;
      frames++;
   end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
// ======================================================
// bench top: random traffic both ways, error corners
// ======================================================
module tb_top;
   import dtu_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic line_in;
   logic sout;
   logic tx_write = 1'b0;
   logic rx_read = 1'b0;
   logic [DIV_W-1:0] div = 17'h00002;
   logic [2:0] kind = PAR_NONE;
   logic [7:0] tx_data = 8'h00;
   logic [7:0] rx_data;
   logic [7:0] d;
   dtu_cmd_s cmd = '0;
   dtu_flags_s flags;
   int n_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 23;
   int k;
   always #2 mclk = ~mclk;
   dtu_uart uut (.mclk(mclk), .rst_n(rst_n), .serial_in_pin(line_in),
      .serial_out_pin(sout), .rate_divisor(div), .check_bit_kind(kind),
      .cmd(cmd), .tx_write(tx_write), .tx_data(tx_data),
      .rx_read(rx_read), .rx_data(rx_data), .flags(flags));
   dtu_term term (.mclk(mclk), .div(div), .kind(kind), .tx_line(sout),
      .rx_line(line_in));
   // expected check bit
   function automatic logic par(input logic [7:0] v, input logic [2:0] c);
      case (c)
         PAR_EVEN: return ^v;
         PAR_ODD: return ~^v;
         PAR_MARK: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // one-cycle pulses; all strobes drop together after the edge
   task automatic go(input dtu_cmd_s c, input logic w, input logic r);
      step(1); // an edge between calls, no strobe written twice at once
      cmd = c;
      tx_write = w;
      rx_read = r;
      step(1);
      cmd = '0;
      tx_write = 1'b0;
      rx_read = 1'b0;
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // hang guard, well above the few thousand cycles needed
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         finish_test();
      end
   end
   initial begin
      step(10);
      rst_n = 1'b1;
      step(1);
      check("flags", flags, 6'h00);
      check("line", sout, 1'b1);
      go(7'h08, 1'b0, 1'b0);
      check("transmit_ready", flags.transmit_ready, 1'b1);
      for (int c = 0; c < 5; c++) begin
         kind = c[2:0];
         d = 8'($random(seed));
         tx_data = d;
         k = term.frames + 1;
         go(7'h00, 1'b1, 1'b0);
         for (int t = 0; t < 600 && term.frames < k; t++) step(1);
         check("tx byte", term.got, d);
         if (c < 4) check("tx par", term.gpar, par(d, kind));
         check("tx stop", term.gstop, 1'b1);
         step(20);
         check("drained", flags.transmit_drained, 1'b1);
      end
      k = term.frames + 2;
      tx_data = 8'hA5;
      go(7'h00, 1'b1, 1'b0);
      // second byte waits in holding while the disable is pending
      go(7'h04, 1'b1, 1'b0);
      check("transmit_ready busy", flags.transmit_ready, 1'b0);
      for (int t = 0; t < 900 && term.frames < k; t++) step(1);
      check("drain two", term.frames, k);
      step(40);
      check("tx stopped", flags.transmit_ready, 1'b0);
      $display("tx test done");
      go(7'h48, 1'b0, 1'b0);
      for (int c = 0; c < 5; c++) begin
         kind = c[2:0];
         d = (c == 0) ? 8'hFF : 8'($random(seed));
         term.send(d, par(d, kind), 1'b1);
         check("receive_ready", flags.receive_ready, 1'b1);
         check("rx byte", rx_data, d);
         check("rx err", flags[4:2], 3'h0);
         go(7'h00, 1'b0, 1'b1);
         check("receive_ready clr", flags.receive_ready, 1'b0);
      end
      term.rx_line = 1'b0;
      step(14);
      term.rx_line = 1'b1;
      step(400);
      check("glitch", flags.receive_ready, 1'b0);
      $display("rx test done");
      kind = PAR_EVEN;
      d = 8'($random(seed));
      term.send(d, ~par(d, kind), 1'b0);
      term.send(d, par(d, kind), 1'b1);
      check("errs", flags[4:2], 3'h7);
      go(7'h00, 1'b0, 1'b1);
      term.send(d, par(d, kind), 1'b1);
      check("sticky", flags[4:2], 3'h7);
      go(7'h01, 1'b0, 1'b1);
      check("cleared", flags[4:2], 3'h0);
      $display("error test done");
      for (int i = 0; i < 2; i++) begin
         go(7'h40, 1'b0, 1'b0);
         d = 8'($random(seed));
         fork
            term.send(d, par(d, kind), 1'b1);
            begin
               step(100);
               go(i ? 7'h10 : 7'h20, 1'b0, 1'b0);
            end
         join
         check("stop mid", flags.receive_ready, i ? 1'b0 : 1'b1);
         go(7'h00, 1'b0, 1'b1);
      end
      div = 17'h00000;
      k = term.frames;
      tx_data = 8'h55;
      go(7'h00, 1'b1, 1'b0);
      step(200);
      check("halted", sout, 1'b1);
      go(7'h02, 1'b0, 1'b0);
      check("tx off", flags[1:0], 2'h0);
      div = 17'h00001; // divisor one: a sampling tick every cycle
      step(600);
      check("aborted", term.frames, k);
      $display("control test done");
      finish_test();
   end
endmodule
